// File: rtl/prescaler_params.svh
// Address map, field positions, reset values and timing counts of the clock prescaler.
`ifndef PRESCALER_PARAMS_SVH
`define PRESCALER_PARAMS_SVH

`define CLOCK_DIVIDE_CONTROL_ADDR 8'h28
`define OSCILLATOR_TRIM_ADDR 8'h2C
`define PRESCALER_STATUS_ADDR 8'h30

`define CHANGE_ENABLE_BIT 7
`define CHANGE_ENABLE_WRITE 8'h80
`define SELECT_CODE_MSB 3
`define SELECT_CODE_LSB 0
`define STATUS_PENDING_BIT 4
`define STATUS_CLKOUT_FUSE_BIT 5
`define STATUS_DIV8_FUSE_BIT 6
`define STATUS_WINDOW_BIT 7

`define SELECT_CODE_PLAIN_RESET 4'h0
`define SELECT_CODE_DIV8_RESET 4'h3
`define SELECT_CODE_MAX 4'h8
`define TRIM_RESET 8'h00

`define CHANGE_WINDOW_CYCLES 3'h4
`define STRAP_SETTLE_CYCLES 2'h3

`endif

// File: rtl/prescaler_pkg.sv
// Types shared by the clock prescaler design and its bench.
package prescaler_pkg;

	typedef logic [7:0] apb_addr_t;
	typedef logic [31:0] apb_data_t;
	typedef logic [7:0] reg8_t;
	typedef logic [3:0] select_code_t;

	// Startup, steady running, and waiting for the old period to end.
	typedef enum logic [1:0] {
		STRAP_WAIT = 2'b00,
		RUNNING = 2'b01,
		SWITCHING = 2'b10
	} prescale_state_t;

endpackage : prescaler_pkg

// File: rtl/system_clock_prescaler_and_output.sv
// System clock prescaler with timed change guard, clock output pin and oscillator trim register.
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "prescaler_params.svh"

module system_clock_prescaler_and_output (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_enable,
	input wire prescaler_pkg::apb_addr_t paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire prescaler_pkg::apb_data_t pwdata,
	output prescaler_pkg::apb_data_t prdata,
	output logic pready,
	output logic pslverr,
	input wire logic clock_output_fuse,
	input wire logic divide_by_eight_fuse,
	input wire prescaler_pkg::reg8_t factory_trim_value,
	input wire logic gpio_out,
	input wire logic gpio_oe,
	output logic clock_output_pin_out,
	output logic clock_output_pin_oe,
	output logic cpu_clk_en,
	output logic flash_clk_en,
	output logic io_clk_en,
	output logic adc_clk_en,
	output prescaler_pkg::reg8_t oscillator_trim_out
);
	import prescaler_pkg::*;

	// Period-end compare value for a code; reserved codes fall back to the slowest factor.
	function automatic reg8_t period_mask(input select_code_t code);
		reg8_t mask;
		mask = 8'h00;
		if (code >= `SELECT_CODE_MAX) begin
			mask = 8'hFF;
		end else begin
			mask = 8'((9'h001 << code) - 9'h001);
		end
		return mask;
	endfunction : period_mask

	// True when the address is one of the mapped registers.
	function automatic logic addr_mapped(input apb_addr_t addr);
		logic hit;
		hit = 1'b0;
		if (addr == `CLOCK_DIVIDE_CONTROL_ADDR) begin
			hit = 1'b1;
		end else if (addr == `OSCILLATOR_TRIM_ADDR) begin
			hit = 1'b1;
		end else if (addr == `PRESCALER_STATUS_ADDR) begin
			hit = 1'b1;
		end
		return hit;
	endfunction : addr_mapped

	prescale_state_t state_reg;
	prescale_state_t state_next;
	logic [2:0] clkout_fuse_sync_reg;
	logic [2:0] div8_fuse_sync_reg;
	reg8_t trim_held_reg;
	reg8_t trim_strap;
	logic div8_strap;
	reg8_t trim_sync1_reg;
	reg8_t trim_sync2_reg;
	reg8_t trim_sync3_reg;
	logic clkout_fuse_reg;
	logic div8_fuse_reg;
	logic [1:0] settle_reg;
	select_code_t active_code_reg;
	select_code_t stored_code_reg;
	logic change_enable_reg;
	logic [2:0] window_reg;
	reg8_t count_reg;
	reg8_t count_next;
	reg8_t mask_now;
	reg8_t mask_next;
	logic period_end;
	logic level_reg;
	logic pass_reg;
	logic run_reg;
	reg8_t trim_reg;
	apb_data_t prdata_reg;
	logic wr_access;
	logic wr_control;
	logic wr_trim;
	logic enable_write;
	logic code_write;

	// Writes take effect only at the completing edge of the access phase.
	// The slave never stretches a transfer, so pready is the clock enable itself: a stalled
	// block answers nothing, and a running one answers in the first access cycle.
	assign pready = clk_enable;
	assign pslverr = psel & penable & ~addr_mapped(paddr);
	assign prdata = prdata_reg;
	assign wr_access = psel & penable & pwrite & clk_enable & addr_mapped(paddr);
	assign wr_control = wr_access & (paddr == `CLOCK_DIVIDE_CONTROL_ADDR);
	assign wr_trim = wr_access & (paddr == `OSCILLATOR_TRIM_ADDR);
	assign enable_write = wr_control & (pwdata[7:0] == `CHANGE_ENABLE_WRITE);
	assign code_write = wr_control & ~pwdata[`CHANGE_ENABLE_BIT];

	// Fuse pins and the factory trim word come from outside the clock domain.
	// The first stage feeds only the second; a value counts once stages two and three agree.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clkout_fuse_sync_reg <= 3'h0;
			div8_fuse_sync_reg <= 3'h0;
			trim_sync1_reg <= `TRIM_RESET;
			trim_sync2_reg <= `TRIM_RESET;
			trim_sync3_reg <= `TRIM_RESET;
			clkout_fuse_reg <= 1'b0;
			div8_fuse_reg <= 1'b0;
			trim_held_reg <= `TRIM_RESET;
		end else if (clk_enable) begin
			clkout_fuse_sync_reg <= {clkout_fuse_sync_reg[1:0], clock_output_fuse};
			div8_fuse_sync_reg <= {div8_fuse_sync_reg[1:0], divide_by_eight_fuse};
			trim_sync1_reg <= factory_trim_value;
			trim_sync2_reg <= trim_sync1_reg;
			trim_sync3_reg <= trim_sync2_reg;
			if (clkout_fuse_sync_reg[1] == clkout_fuse_sync_reg[2]) begin
				clkout_fuse_reg <= clkout_fuse_sync_reg[2];
			end
			if (div8_fuse_sync_reg[1] == div8_fuse_sync_reg[2]) begin
				div8_fuse_reg <= div8_fuse_sync_reg[2];
			end
			if (trim_sync2_reg == trim_sync3_reg) begin
				trim_held_reg <= trim_sync3_reg;
			end
		end
	end

	// Strap values as they stand after this edge: a fresh agreement of stages two and three
	// wins, otherwise the last agreed value holds. The start-up load reads these, so it never
	// takes a fuse register that is still one edge behind its own synchroniser.
	assign div8_strap = (div8_fuse_sync_reg[1] == div8_fuse_sync_reg[2]) ? div8_fuse_sync_reg[2]
		: div8_fuse_reg;
	assign trim_strap = (trim_sync2_reg == trim_sync3_reg) ? trim_sync3_reg : trim_held_reg;

	// Counts out the synchroniser depth after reset release before the straps are trusted.
	// It stops once the straps are taken, so two bits suffice for the three-edge wait.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_reg <= 2'h0;
		end else if (clk_enable && state_reg == STRAP_WAIT) begin
			settle_reg <= 2'(settle_reg + 2'h1);
		end
	end

	// Main sequencing: wait for straps, run, and hold a new code until the old period ends.
	// A second code accepted while a switch is pending only replaces the stored code; the
	// divider takes whatever code stands when the old period ends, so no period is cut short.
	// Control writes before the straps are loaded are dropped, since the reset code is not set.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			STRAP_WAIT: begin
				if (settle_reg == `STRAP_SETTLE_CYCLES) begin
					state_next = RUNNING;
				end
			end
			RUNNING: begin
				if (code_write && change_enable_reg) begin
					state_next = SWITCHING;
				end
			end
			SWITCHING: begin
				if (period_end) begin
					state_next = RUNNING;
				end
			end
			default: begin
				state_next = STRAP_WAIT;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= STRAP_WAIT;
		end else if (clk_enable) begin
			state_reg <= state_next;
		end
	end

	// The control register code and the code the divider actually uses.
	// Keeping them apart lets the old period finish before the new factor takes hold.
	// The start-up code reads the resolved strap, not the fuse register, because that
	// register only catches up with its synchroniser on the very edge of the load.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stored_code_reg <= `SELECT_CODE_PLAIN_RESET;
			active_code_reg <= `SELECT_CODE_PLAIN_RESET;
		end else if (clk_enable) begin
			if (state_reg == STRAP_WAIT && state_next == RUNNING) begin
				stored_code_reg <= div8_strap ? `SELECT_CODE_DIV8_RESET
					: `SELECT_CODE_PLAIN_RESET;
				active_code_reg <= div8_strap ? `SELECT_CODE_DIV8_RESET
					: `SELECT_CODE_PLAIN_RESET;
			end else begin
				if (code_write && change_enable_reg && state_reg != STRAP_WAIT) begin
					stored_code_reg <= pwdata[`SELECT_CODE_MSB:`SELECT_CODE_LSB];
				end
				if (state_reg == SWITCHING && period_end) begin
					active_code_reg <= stored_code_reg;
				end
			end
		end
	end

	// Change-enable window: opens only from closed, closes on timeout or on a code write.
	// The window counts enabled master clock cycles. Because the enable sets only while it
	// is clear, a hardware clear and a software set never meet in one cycle, and a rewrite
	// inside the window falls through to the counting branch without restarting it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			change_enable_reg <= 1'b0;
			window_reg <= 3'h0;
		end else if (clk_enable) begin
			if (!change_enable_reg) begin
				if (enable_write && state_reg != STRAP_WAIT) begin
					change_enable_reg <= 1'b1;
					window_reg <= 3'h1;
				end
			end else if (code_write) begin
				change_enable_reg <= 1'b0;
				window_reg <= 3'h0;
			end else if (window_reg == `CHANGE_WINDOW_CYCLES) begin
				change_enable_reg <= 1'b0;
				window_reg <= 3'h0;
			end else begin
				window_reg <= 3'(window_reg + 3'h1);
			end
		end
	end

	// Divider arithmetic on the master clock; the count itself is never mapped to software.
	// Reserved codes divide like the largest factor instead of stopping the clock, so a
	// careless write can slow the system down but never freeze it.
	// The next mask already reflects a pending switch, so the new level starts on time.
	always_comb begin
		mask_now = period_mask(active_code_reg);
		period_end = (count_reg >= mask_now);
		if (period_end) begin
			count_next = 8'h00;
		end else begin
			count_next = 8'(count_reg + 8'h01);
		end
		if (state_reg == SWITCHING && period_end) begin
			mask_next = period_mask(stored_code_reg);
		end else begin
			mask_next = mask_now;
		end
	end

	// Divided clock level is high in the first half of each period but the first after reset, whose count 0 cycle
	// stays low; every later period starts with a rising edge and a switch can only happen on a whole-period boundary.
	// The count is held while the straps settle, so the first period after reset is whole.
	// The level is registered, so the pin never shows a decode glitch of the counter.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= 8'h00;
			level_reg <= 1'b0;
			pass_reg <= 1'b0;
			run_reg <= 1'b0;
		end else if (clk_enable) begin
			if (state_reg != STRAP_WAIT) begin
				count_reg <= count_next;
				level_reg <= (count_next <= (mask_next >> 1));
				pass_reg <= (mask_next == 8'h00);
			end
			run_reg <= (state_next != STRAP_WAIT);
		end
	end

	// One enable pulse per divided period feeds every synchronous domain alike.
	// The pulses are combinational so that a stalled block drops them in the same cycle;
	// every consumer samples them on the master clock, never on a divided edge.
	// Sharing one pulse keeps the domains in step; none can run ahead of another.
	always_comb begin
		cpu_clk_en = run_reg & clk_enable & (count_reg == 8'h00);
		flash_clk_en = cpu_clk_en;
		io_clk_en = cpu_clk_en;
		adc_clk_en = cpu_clk_en;
	end

	// Pin mux. Divide-by-one passes the master clock gated by a flop; the gate changes only
	// right after a rising edge, where both sources are high, so the hand-over is clean.
	// With the fuse clear the pin belongs to the port logic in every cycle, reset included.
	// During reset the fuse register is cleared, so the pin cannot carry the clock then.
	// The fuse is sampled only through its synchroniser, so a bouncing strap cannot glitch.
	always_comb begin
		if (clkout_fuse_reg) begin
			clock_output_pin_oe = 1'b1;
			if (pass_reg) begin
				clock_output_pin_out = run_reg & pclk;
			end else begin
				clock_output_pin_out = run_reg & level_reg;
			end
		end else begin
			clock_output_pin_oe = gpio_oe;
			clock_output_pin_out = gpio_out;
		end
	end

	// Trim register: factory value is taken once the synchronisers settle after release,
	// then software owns it. Bit 7 picks the range and bits 6..0 tune within it.
	// The oscillator follows the register directly. This block cannot see memory writes,
	// so software alone must keep the trim low enough while those are in progress.
	// A write is never range checked; any byte is taken as it stands.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trim_reg <= `TRIM_RESET;
		end else if (clk_enable) begin
			if (state_reg == STRAP_WAIT && state_next == RUNNING) begin
				trim_reg <= trim_strap;
			end else if (wr_trim) begin
				trim_reg <= pwdata[7:0];
			end
		end
	end

	assign oscillator_trim_out = trim_reg;

	// Read data is captured in the setup phase so it stands through the access phase.
	// The price is one cycle of age: a field that changes during the access phase is
	// reported as it stood at the setup edge.
	// Unmapped addresses read as zero, and the error flag tells software why.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (clk_enable && psel && !penable && !pwrite) begin
			prdata_reg <= 32'h0000_0000;
			if (paddr == `CLOCK_DIVIDE_CONTROL_ADDR) begin
				prdata_reg[`CHANGE_ENABLE_BIT] <= change_enable_reg;
				prdata_reg[`SELECT_CODE_MSB:`SELECT_CODE_LSB] <= stored_code_reg;
			end else if (paddr == `OSCILLATOR_TRIM_ADDR) begin
				prdata_reg[7:0] <= trim_reg;
			end else if (paddr == `PRESCALER_STATUS_ADDR) begin
				prdata_reg[`SELECT_CODE_MSB:`SELECT_CODE_LSB] <= active_code_reg;
				prdata_reg[`STATUS_PENDING_BIT] <= (state_reg == SWITCHING);
				prdata_reg[`STATUS_CLKOUT_FUSE_BIT] <= clkout_fuse_reg;
				prdata_reg[`STATUS_DIV8_FUSE_BIT] <= div8_fuse_reg;
				prdata_reg[`STATUS_WINDOW_BIT] <= (state_reg != STRAP_WAIT);
			end
		end
	end

endmodule : system_clock_prescaler_and_output
`default_nettype wire

// File: testbench/prescaler_properties.sv
// Port-level checks for the clock prescaler.
`timescale 1ns/10ps
`default_nettype none
`include "prescaler_params.svh"
module prescaler_properties
	import prescaler_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_enable,
	input wire prescaler_pkg::apb_addr_t paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire prescaler_pkg::apb_data_t pwdata,
	input wire prescaler_pkg::apb_data_t prdata,
	input wire logic pready,
	input wire logic clock_output_fuse,
	input wire prescaler_pkg::reg8_t factory_trim_value,
	input wire logic gpio_out,
	input wire logic gpio_oe,
	input wire logic clock_output_pin_out,
	input wire logic clock_output_pin_oe,
	input wire logic cpu_clk_en,
	input wire logic flash_clk_en,
	input wire logic io_clk_en,
	input wire logic adc_clk_en,
	input wire prescaler_pkg::reg8_t oscillator_trim_out
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus events and the byte written, kept as nets so the checks stay short.
	wire logic take = psel && penable && pready;
	wire logic ctl_hit = take && paddr == `CLOCK_DIVIDE_CONTROL_ADDR;
	wire reg8_t wbyte = pwdata[7:0];
	logic [9:0] gap_reg;
	logic seen_reg;
	logic [2:0] since_reg;
	// Enabled cycles between system clock pulses; stalled cycles are not counted.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_reg <= 10'h000;
			seen_reg <= 1'b0;
		end else if (cpu_clk_en) begin
			gap_reg <= 10'h001;
			seen_reg <= 1'b1;
		end else if (clk_enable && gap_reg != 10'h3FF) begin
			gap_reg <= gap_reg + 10'h001;
		end
	end
	// Age of the last enable-only write; saturates so it never wraps into a false pass.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_reg <= 3'h7;
		end else if (ctl_hit && pwrite && wbyte == 8'h80) begin
			since_reg <= 3'h0;
		end else if (clk_enable && since_reg != 3'h7) begin
			since_reg <= since_reg + 3'h1;
		end
	end
	en_equal_a: assert property (cpu_clk_en == flash_clk_en && cpu_clk_en == io_clk_en
		&& cpu_clk_en == adc_clk_en) else $error("clock enables differ");
	gap_pow2_a: assert property (cpu_clk_en && seen_reg |-> gap_reg <= 10'd256
		&& (gap_reg & (gap_reg - 10'd1)) == 10'd0) else $error("bad clock period");
	pin_gpio_a: assert property (!clock_output_fuse [*5]
		|-> clock_output_pin_out == gpio_out && clock_output_pin_oe == gpio_oe)
		else $error("pin left port logic");
	pin_drive_a: assert property (clock_output_fuse [*5] |-> clock_output_pin_oe)
		else $error("pin not driven");
	reset_quiet_a: assert property (disable iff (1'b0)
		!presetn |-> clock_output_pin_out == gpio_out) else $error("pin moved in reset");
	ctl_zero_a: assert property (ctl_hit && !pwrite |-> prdata[6:4] == 3'h0
		&& prdata[31:8] == 24'h00_0000) else $error("reserved bits set");
	window_close_a: assert property (ctl_hit && !pwrite && prdata[7]
		|-> since_reg <= 3'd5) else $error("enable held too long");
	trim_load_a: assert property ($rose(presetn)
		|-> ##[4:6] oscillator_trim_out == factory_trim_value) else $error("trim not loaded");
	trim_write_a: assert property (take && pwrite && paddr == `OSCILLATOR_TRIM_ADDR
		|=> oscillator_trim_out == $past(wbyte)) else $error("trim write lost");
	cover property (ctl_hit && pwrite && wbyte == 8'h80);
	cover property (cpu_clk_en && gap_reg == 10'd256);
	cover property (clock_output_fuse && clock_output_pin_oe);
endmodule : prescaler_properties
bind system_clock_prescaler_and_output prescaler_properties u_prescaler_properties (.*);
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the clock prescaler.
`timescale 1ns/10ps
`default_nettype none
`include "prescaler_params.svh"
module tb_top;
	import prescaler_pkg::*;
	localparam apb_addr_t ctl = `CLOCK_DIVIDE_CONTROL_ADDR;
	localparam apb_addr_t trim = `OSCILLATOR_TRIM_ADDR;
	logic pclk = 1'b0, presetn = 1'b0, clk_enable = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, clock_output_fuse = 1'b0, divide_by_eight_fuse = 1'b1;
	logic gpio_out = 1'b0, gpio_oe = 1'b1, clock_output_pin_out, clock_output_pin_oe;
	logic cpu_clk_en, flash_clk_en, io_clk_en, adc_clk_en;
	apb_addr_t paddr = 8'h00;
	apb_data_t pwdata = 32'h0000_0000, prdata, g;
	logic err = 1'b0;
	reg8_t factory_trim_value = 8'hA5, oscillator_trim_out;
	int mismatches = 0, cmp_count = 0, cycles = 0;
	system_clock_prescaler_and_output u_system_clock_prescaler_and_output (.*);
	always #50 pclk = ~pclk;
	task automatic wrap_up;
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up
	// A hang is cut short here and counted as a failure.
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			wrap_up;
		end
	end
	task automatic check(input apb_data_t seen, input apb_data_t exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// One transfer; the request stands until pready is seen high at an edge.
	task automatic apb(input apb_addr_t a, input logic w, input reg8_t d, output apb_data_t r);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input apb_addr_t a, input reg8_t d);
		apb_data_t r;
		apb(a, 1'b1, d, r);
	endtask : wr
	task automatic rd(input apb_addr_t a, input apb_data_t exp);
		apb_data_t r;
		apb(a, 1'b0, 8'h00, r);
		check(r, exp);
	endtask : rd
	// Cycles between two system clock pulses, sampled away from the edge.
	task automatic gap(output apb_data_t n);
		n = 32'h0000_0000;
		@(negedge pclk);
		while (cpu_clk_en !== 1'b1) @(negedge pclk);
		do begin
			@(negedge pclk);
			n++;
		end while (cpu_clk_en !== 1'b1);
	endtask : gap
	task automatic set_code(input reg8_t n);
		wr(ctl, `CHANGE_ENABLE_WRITE);
		wr(ctl, n);
	endtask : set_code
	task automatic t_reset(input apb_data_t code, input apb_data_t per);
		rd(ctl, code);
		rd(trim, {24'h00_0000, factory_trim_value});
		gap(g);
		gap(g);
		check(g, per);
	endtask : t_reset
	task automatic t_codes;
		for (int n = 0; n <= 8; n++) begin
			set_code(n[7:0]);
			rd(ctl, apb_data_t'(n));
			gap(g);
			gap(g);
			check(g, 32'h0000_0001 << n);
		end
	endtask : t_codes
	// Writes that must not reach the divider: bare code, impure enable, late code.
	task automatic t_guard;
		set_code(8'h02);
		wr(ctl, 8'h05);
		rd(ctl, 32'h0000_0002);
		wr(ctl, 8'h81);
		wr(ctl, 8'h05);
		rd(ctl, 32'h0000_0002);
		wr(ctl, 8'h80);
		rd(ctl, 32'h0000_0082);
		repeat (3) @(posedge pclk);
		wr(ctl, 8'h05);
		rd(ctl, 32'h0000_0002);
		wr(ctl, 8'h80);
		wr(ctl, 8'h80);
		@(posedge pclk);
		wr(ctl, 8'h05);
		rd(ctl, 32'h0000_0002);
		gap(g);
		check(g, 32'h0000_0004);
	endtask : t_guard
	task automatic t_pin;
		@(posedge pclk);
		gpio_out <= 1'b1;
		gpio_oe <= 1'b0;
		@(negedge pclk);
		check({clock_output_pin_oe, clock_output_pin_out}, 32'h0000_0001);
		@(posedge pclk);
		clock_output_fuse <= 1'b1;
		repeat (5) @(posedge pclk);
		@(negedge pclk);
		check(clock_output_pin_oe, 32'h0000_0001);
		g = 32'h0000_0000;
		repeat (64) begin
			@(negedge pclk);
			g += clock_output_pin_out;
		end
		check(g, 32'h0000_0020);
	endtask : t_pin
	task automatic t_trim;
		wr(trim, 8'h7F);
		@(negedge pclk);
		check(oscillator_trim_out, 32'h0000_007F);
		wr(trim, 8'h80);
		rd(trim, 32'h0000_0080);
	endtask : t_trim
	// A low clock enable stalls the bus and the divider; no pulse may escape meanwhile.
	task automatic t_stall;
		@(posedge pclk);
		clk_enable <= 1'b0;
		repeat (6) begin
			@(negedge pclk);
			check({pready, cpu_clk_en, adc_clk_en}, 32'h0000_0000);
		end
		@(posedge pclk);
		clk_enable <= 1'b1;
		gap(g);
		check(g, 32'h0000_0004);
	endtask : t_stall
	// Second reset with the output fuse on: the pin must keep its port level.
	task automatic t_rerun;
		@(posedge pclk);
		presetn <= 1'b0;
		divide_by_eight_fuse <= 1'b0;
		repeat (3) begin
			@(negedge pclk);
			check(clock_output_pin_out, gpio_out);
		end
		@(posedge pclk);
		presetn <= 1'b1;
		repeat (5) @(posedge pclk);
		t_reset(32'h0000_0000, 32'h0000_0001);
	endtask : t_rerun
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (5) @(posedge pclk);
		t_reset(32'h0000_0003, 32'h0000_0008);
		t_codes;
		t_guard;
		t_pin;
		t_trim;
		t_stall;
		t_rerun;
		wr(8'h40, 8'h80);
		check(err, 1'b1);
		rd(ctl, 32'h0000_0000);
		wrap_up;
	end
endmodule : tb_top
`default_nettype wire
